// [include/skt_defs.svh]
`ifndef SKT_DEFS_SVH
`define SKT_DEFS_SVH
// Overview of operation
// - The accumulator-equals-memory test makes the next instruction a no-operation when the accumulator matches the pointed memory nibble.
// - With the external 0 interrupt enable cleared, the external 0 flag test skips the next instruction when the external 0 request flag is one.
// - After the external 0 flag test has skipped, the external 0 request flag is cleared to zero unless a new external 0 request arrives in the same cycle.
// - When the external 0 request flag is zero, the external 0 flag test does not skip and the next instruction runs normally.
// - With the external 1 interrupt enable cleared, the external 1 flag test skips the next instruction when the external 1 request flag is one.
// - After the external 1 flag test has skipped, the external 1 request flag is cleared to zero unless a new external 1 request arrives in the same cycle.

`define SKT_NIBBLE_W 4
`define SKT_FLAG_RST 1'b0
`define SKT_SKIP_RST 1'b0
`define SKT_PULSE_RST 1'b0

`endif

// [include/skt_pkg.sv]
package skt_pkg;

    // Decoded class of the instruction in the execute stage.
    typedef enum logic [1:0] {
        SKT_OP_OTHER,
        SKT_OP_ACC_EQ_MEM,
        SKT_OP_EXT0_TEST,
        SKT_OP_EXT1_TEST
    } skt_op_e;

    // Execute stage state: run normally or squash the next instruction.
    typedef enum logic {
        SKT_ST_RUN,
        SKT_ST_SQUASH
    } skt_state_e;

endpackage : skt_pkg

// [design/skt_flag_cell.sv]
`timescale 1ns/1ps
`include "skt_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Request flag: a hardware set wins over an instruction clear in the same cycle.
module skt_flag_cell (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Control.
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    // State.
    output logic      flag_r
);

    logic flag_nxt;

    always_comb begin
        flag_nxt = flag_r;
        if (clr_pulse) begin
            flag_nxt = 1'b0;
        end
        if (set_pulse) begin
            flag_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_r <= `SKT_FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

endmodule : skt_flag_cell

// [design/skt_skip_test.sv]
`timescale 1ns/1ps
`include "skt_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Skip-type instruction execution: equality test and external request tests.
module skt_skip_test (
    // Clock and reset.
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    // Instruction from the execute stage.
    input  wire logic                      instr_valid,
    input  wire skt_pkg::skt_op_e          instr_op,
    // Operands.
    input  wire logic [`SKT_NIBBLE_W-1:0]  acc,
    input  wire logic [`SKT_NIBBLE_W-1:0]  pointed_memory_nibble,
    // Interrupt control bits.
    input  wire logic                      ext0_irq_enable,
    input  wire logic                      ext1_irq_enable,
    // Request events from the edge detectors.
    input  wire logic                      ext0_req_set,
    input  wire logic                      ext1_req_set,
    // Request flags.
    output logic                           ext0_request_flag,
    output logic                           ext1_request_flag,
    // Skip control.
    output logic                           skip_next_r,
    output logic                           skipped_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the current instruction.

    skt_pkg::skt_state_e state_r;
    skt_pkg::skt_state_e state_nxt;
    logic                skip_next_nxt;
    logic                skipped_nxt;
    logic                live;
    logic                do_acc_eq;
    logic                do_ext0;
    logic                do_ext1;
    logic                ext0_clr;
    logic                ext1_clr;
    logic                ext0_flag_r;
    logic                ext1_flag_r;

    // A squashed instruction has no effect at all.
    assign live      = instr_valid && (state_r == skt_pkg::SKT_ST_RUN);

    assign do_acc_eq = live && (instr_op == skt_pkg::SKT_OP_ACC_EQ_MEM)
                       && (acc == pointed_memory_nibble);

    assign do_ext0   = live && (instr_op == skt_pkg::SKT_OP_EXT0_TEST)
                       && !ext0_irq_enable && ext0_flag_r;

    assign do_ext1   = live && (instr_op == skt_pkg::SKT_OP_EXT1_TEST)
                       && !ext1_irq_enable && ext1_flag_r;

    // A taken flag test clears its own request.
    assign ext0_clr  = do_ext0;
    assign ext1_clr  = do_ext1;

    ////////////////////////////////////////////////////////////////////////////
    // Request flags.

    skt_flag_cell u_ext0_flag (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .set_pulse (ext0_req_set),
        .clr_pulse (ext0_clr),
        .flag_r    (ext0_flag_r)
    );

    skt_flag_cell u_ext1_flag (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .set_pulse (ext1_req_set),
        .clr_pulse (ext1_clr),
        .flag_r    (ext1_flag_r)
    );

    assign ext0_request_flag = ext0_flag_r;
    assign ext1_request_flag = ext1_flag_r;

    ////////////////////////////////////////////////////////////////////////////
    // Skip state machine.

    always_comb begin
        state_nxt   = state_r;
        skipped_nxt = 1'b0;
        case (state_r)
            skt_pkg::SKT_ST_RUN: begin
                if (do_acc_eq || do_ext0 || do_ext1) begin
                    state_nxt = skt_pkg::SKT_ST_SQUASH;
                end
            end
            skt_pkg::SKT_ST_SQUASH: begin
                if (instr_valid) begin
                    state_nxt   = skt_pkg::SKT_ST_RUN;
                    skipped_nxt = 1'b1;
                end
            end
            default: begin
                state_nxt = skt_pkg::SKT_ST_RUN;
            end
        endcase
        skip_next_nxt = (state_nxt == skt_pkg::SKT_ST_SQUASH);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r     <= skt_pkg::SKT_ST_RUN;
            skip_next_r <= `SKT_SKIP_RST;
            skipped_r   <= `SKT_PULSE_RST;
        end else begin
            state_r     <= state_nxt;
            skip_next_r <= skip_next_nxt;
            skipped_r   <= skipped_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_acc_eq_skip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_ACC_EQ_MEM
         && acc == pointed_memory_nibble) |=> skip_next_r)
        else $error("Equal accumulator did not arm the skip.");

    a_acc_ne_run: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_ACC_EQ_MEM
         && acc != pointed_memory_nibble) |=> !skip_next_r)
        else $error("Unequal accumulator armed the skip.");

    a_ext0_skip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT0_TEST
         && !ext0_irq_enable && ext0_request_flag) |=> skip_next_r)
        else $error("External 0 test did not skip on a set flag.");

    a_ext0_clear: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT0_TEST
         && !ext0_irq_enable && ext0_request_flag && !ext0_req_set)
        |=> !ext0_request_flag)
        else $error("External 0 flag not cleared after skip.");

    a_ext0_noskip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT0_TEST
         && !ext0_request_flag) |=> !skip_next_r)
        else $error("External 0 test skipped on a clear flag.");

    a_ext1_skip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT1_TEST
         && !ext1_irq_enable && ext1_request_flag) |=> skip_next_r)
        else $error("External 1 test did not skip on a set flag.");

    a_ext1_clear: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT1_TEST
         && !ext1_irq_enable && ext1_request_flag && !ext1_req_set)
        |=> !ext1_request_flag)
        else $error("External 1 flag not cleared after skip.");

    a_squash_one: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && skip_next_r) |=> (skipped_r && !skip_next_r))
        else $error("Squashed instruction not consumed in one cycle.");

    a_squash_keeps: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && skip_next_r && ext0_request_flag
         && instr_op == skt_pkg::SKT_OP_EXT0_TEST) |=> ext0_request_flag)
        else $error("Squashed flag test changed its flag.");

    a_set_wins: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ext0_req_set |=> ext0_request_flag)
        else $error("External 0 request event was lost.");

    a_ext1_set_wins: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        ext1_req_set |=> ext1_request_flag)
        else $error("External 1 request event was lost.");

    a_ext1_kept: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && skip_next_r && ext1_request_flag
         && instr_op == skt_pkg::SKT_OP_EXT1_TEST) |=> ext1_request_flag)
        else $error("Squashed external 1 test changed its flag.");

    a_ext0_en_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT0_TEST
         && ext0_irq_enable) |=> !skip_next_r)
        else $error("External 0 test skipped with its enable set.");

    a_ext1_en_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT1_TEST
         && ext1_irq_enable) |=> !skip_next_r)
        else $error("External 1 test skipped with its enable set.");

    a_ext1_noskip: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (instr_valid && !skip_next_r && instr_op == skt_pkg::SKT_OP_EXT1_TEST
         && !ext1_request_flag) |=> !skip_next_r)
        else $error("External 1 test skipped on a clear flag.");

    a_idle_no_pulse: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !(instr_valid && skip_next_r) |=> !skipped_r)
        else $error("Skip pulse without a squashed instruction.");

    a_ext0_clear_only: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        (ext0_request_flag && !(instr_valid && !skip_next_r && !ext0_irq_enable
         && instr_op == skt_pkg::SKT_OP_EXT0_TEST)) |=> ext0_request_flag)
        else $error("External 0 flag cleared without a taken test.");

endmodule : skt_skip_test

// [sim/skt_testbench.sv]
`timescale 1ns/1ps
`include "skt_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Drives the skip-test block at the falling edge and checks its outputs.
module testbench;
    logic                     sys_clk = 1'b0;
    logic                     resetn = 1'b0;
    logic                     instr_valid = 1'b0;
    skt_pkg::skt_op_e         instr_op = skt_pkg::SKT_OP_OTHER;
    logic [`SKT_NIBBLE_W-1:0] acc = 4'h0;
    logic [`SKT_NIBBLE_W-1:0] mem = 4'h0;
    logic                     en0 = 1'b0;
    logic                     en1 = 1'b0;
    logic                     set0 = 1'b0;
    logic                     set1 = 1'b0;
    logic                     flag0;
    logic                     flag1;
    logic                     skip;
    logic                     skipped;
    int                       errors = 0;
    int                       samples_checked = 0;

    always #20 sys_clk = ~sys_clk;

    skt_skip_test u_skt_skip_test (
        .sys_clk               (sys_clk),
        .resetn                (resetn),
        .instr_valid           (instr_valid),
        .instr_op              (instr_op),
        .acc                   (acc),
        .pointed_memory_nibble (mem),
        .ext0_irq_enable       (en0),
        .ext1_irq_enable       (en1),
        .ext0_req_set          (set0),
        .ext1_req_set          (set1),
        .ext0_request_flag     (flag0),
        .ext1_request_flag     (flag1),
        .skip_next_r           (skip),
        .skipped_r             (skipped)
    );

    ////////////////////////////////////////////////////////////////////////////
    task check(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %b expected %b", $time, got, exp);
        end
    endtask : check

    task end_sim;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // Presents one instruction for one edge and leaves it up for a follower.
    task instr(input skt_pkg::skt_op_e op, input logic [3:0] a, input logic [3:0] m);
        instr_valid = 1'b1;
        instr_op = op;
        acc = a;
        mem = m;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : instr

    task idle;
        instr_valid = 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : idle

    task pulse(input logic w);
        if (w) begin
            set1 = 1'b1;
        end else begin
            set0 = 1'b1;
        end
        @(posedge sys_clk);
        @(negedge sys_clk);
        set0 = 1'b0;
        set1 = 1'b0;
    endtask : pulse

    // Flag test sequence for one external request line.
    task run_ext(input logic w);
        skt_pkg::skt_op_e op;
        op = w ? skt_pkg::SKT_OP_EXT1_TEST : skt_pkg::SKT_OP_EXT0_TEST;
        instr(op, 4'h0, 4'h0);
        check(skip, 1'b0);
        idle();
        pulse(w);
        instr(op, 4'h0, 4'h0);
        check(skip, 1'b1);
        check(w ? flag1 : flag0, 1'b0);
        pulse(w);
        instr(skt_pkg::SKT_OP_ACC_EQ_MEM, 4'h3, 4'h3);
        instr(op, 4'h0, 4'h0);
        check(skip, 1'b0);
        check(w ? flag1 : flag0, 1'b1);
        check(skipped, 1'b1);
        if (w) begin
            en1 = 1'b1;
        end else begin
            en0 = 1'b1;
        end
        instr(op, 4'h0, 4'h0);
        check(skip, 1'b0);
        check(w ? flag1 : flag0, 1'b1);
        en0 = 1'b0;
        en1 = 1'b0;
        instr(op, 4'h0, 4'h0);
        check(skip, 1'b1);
        check(w ? flag1 : flag0, 1'b0);
        instr(skt_pkg::SKT_OP_OTHER, 4'h0, 4'h0);
        check(skip, 1'b0);
        check(skipped, 1'b1);
        idle();
        pulse(w);
        set0 = !w;
        set1 = w;
        instr(op, 4'h0, 4'h0);
        set0 = 1'b0;
        set1 = 1'b0;
        check(skip, 1'b1);
        check(w ? flag1 : flag0, 1'b1);
        instr(skt_pkg::SKT_OP_OTHER, 4'h0, 4'h0);
        check(skipped, 1'b1);
        idle();
        $display("flag test %0d done", w);
    endtask : run_ext

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2000) @(posedge sys_clk);
        errors++;
        end_sim();
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check(skip, 1'b0);
        check(flag0 | flag1 | skipped, 1'b0);
        resetn = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            instr(skt_pkg::SKT_OP_ACC_EQ_MEM, 4'(i), 4'(i));
            check(skip, 1'b1);
            instr(skt_pkg::SKT_OP_ACC_EQ_MEM, 4'(i), 4'(i));
            check(skip, 1'b0);
            check(skipped, 1'b1);
            instr(skt_pkg::SKT_OP_ACC_EQ_MEM, 4'(i), 4'(i + 1));
            check(skip, 1'b0);
            check(skipped, 1'b0);
        end
        idle();
        $display("equality test done");
        run_ext(1'b0);
        run_ext(1'b1);
        end_sim();
    end
endmodule : testbench
